// [rtl/rcr_consts.vh]
`ifndef RCR_CONSTS_VH
`define RCR_CONSTS_VH

// ----------------------------------------------------------------
// register location
// ----------------------------------------------------------------
`define RCR_SFR_ADDR 8'hEF
`define RCR_SFR_PAGE 8'h00

// ----------------------------------------------------------------
// bit positions of the reset cause and enable register
// ----------------------------------------------------------------
`define RCR_BIT_RTC 7
`define RCR_BIT_FLASH 6
`define RCR_BIT_CMP 5
`define RCR_BIT_SW 4
`define RCR_BIT_WDT 3
`define RCR_BIT_MCD 2
`define RCR_BIT_POR 1
`define RCR_BIT_PIN 0

// ----------------------------------------------------------------
// reset values after power-on
// ----------------------------------------------------------------
`define RCR_CAUSE_POR_VAL 8'h02
`define RCR_RTC_EN_RST 1'b0
`define RCR_CMP_EN_RST 1'b0
`define RCR_MCD_EN_RST 1'b0
`define RCR_SUPPLY_EN_RST 1'b1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RCR_CLK_PERIOD_NS 50
`define RCR_MCD_TIME_US 100
// 100 us in 50 ns clock cycles, sized to the detector's 12-bit counter
`define RCR_MCD_CYCLES 12'h7D0
`define RCR_HOLD_CYCLES 8'h10

`endif

// [rtl/rcr_clock_loss_detector.v]
`timescale 1ns/100ps

`include "rcr_consts.vh"

module rcr_clock_loss_detector
#(
	parameter CNT_W = 12,
	parameter [CNT_W-1:0] LIMIT = `RCR_MCD_CYCLES
)
(
	// clock and reset
	input wire clk_i,
	input wire rst_b_i,
	// control
	input wire enable_i,
	// monitored clock, sampled as a level
	input wire mon_clk_i,
	// stuck clock seen
	output reg timeout_o
);

	reg mon_prev;
	reg [CNT_W-1:0] cnt;

	// ----------------------------------------------------------------
	// stuck-level timer
	// ----------------------------------------------------------------
	// any edge of the monitored clock restarts the one-shot
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			mon_prev <= 1'b0;
			cnt <= {CNT_W{1'b0}};
			timeout_o <= 1'b0;
		end
		else
		begin
			mon_prev <= mon_clk_i;
			if (!enable_i || mon_clk_i != mon_prev)
			begin
				cnt <= {CNT_W{1'b0}};
				timeout_o <= 1'b0;
			end
			else if (cnt >= LIMIT)
				timeout_o <= 1'b1;
			else
				cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

endmodule

// [rtl/rcr_reset_cause_recorder.v]
// Notes on behaviour
// - bit 7: rtc source enable, rtc cause flag
// - bit 6: read-only flash error cause flag
// - bit 5: comparator enable, comparator cause flag
// - bit 4 write one forces reset, flags it
// - bit 3: read-only watchdog overflow cause flag
// - bit 2: clock loss enable and flag
// - bit 1: supply enable; power-on or supply flag
// - power-on flag set: other bits read zero
// - bit 0: read-only external pin cause flag
// - read-modify-write rewrites cause no side effects
// - register at address 0xEF, page 0
// - clock stuck over 100 us resets
// - clock loss off in low power, restored
`timescale 1ns/100ps

`include "rcr_consts.vh"

module rcr_reset_cause_recorder
#(
	parameter HOLD_W = 8,
	parameter [HOLD_W-1:0] HOLD_CYCLES = `RCR_HOLD_CYCLES,
	parameter MCD_W = 12,
	parameter [MCD_W-1:0] MCD_CYCLES = `RCR_MCD_CYCLES
)
(
	// clock and power-on reset
	input wire clk_i,
	input wire rst_b_i,
	// special-function register port
	input wire [7:0] sfr_addr_i,
	input wire [7:0] sfr_page_i,
	input wire sfr_wr_i,
	input wire sfr_rd_i,
	input wire sfr_rmw_i,
	input wire [7:0] sfr_wdata_i,
	output reg [7:0] sfr_rdata_o,
	// reset sources
	input wire ext_pin_reset_b_i,
	input wire supply_low_i,
	input wire mon_clk_i,
	input wire low_power_i,
	input wire watchdog_overflow_i,
	input wire flash_error_i,
	input wire comparator_out_i,
	input wire rtc_event_i,
	// system reset and enables
	output reg sys_reset_b_o,
	output wire rtc_reset_enable_o,
	output wire comparator_reset_enable_o,
	output wire clock_loss_enable_o,
	output wire supply_reset_enable_o
);

	localparam ST_RUN = 1'b0;
	localparam ST_HOLD = 1'b1;

	reg state;
	reg next_state;
	reg [HOLD_W-1:0] hold_cnt;
	reg [HOLD_W-1:0] next_hold_cnt;
	reg [7:0] cause;
	reg [7:0] pending;
	reg [7:0] next_pending;
	reg rtc_reset_enable_flag;
	reg comparator_reset_enable_flag;
	reg clock_loss_reset_enable_flag;
	reg supply_reset_enable;
	wire sel;
	wire wr_hit;
	wire clock_loss_timeout;
	wire clock_loss_active;
	wire [7:0] req;
	wire any_req;
	wire pin_held;
	wire [7:0] flag_view;
	wire [7:0] rmw_view;

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	assign sel = (sfr_addr_i == `RCR_SFR_ADDR) &&
		(sfr_page_i == `RCR_SFR_PAGE);
	assign wr_hit = sfr_wr_i && sel && (state == ST_RUN);

	// ----------------------------------------------------------------
	// clock loss detector
	// ----------------------------------------------------------------
	// disabling in low power leaves the enable bit untouched, so the
	// previous setting comes back by itself on wake-up
	assign clock_loss_active = clock_loss_reset_enable_flag &&
		!low_power_i;

	rcr_clock_loss_detector
	#(
		.CNT_W(MCD_W),
		.LIMIT(MCD_CYCLES)
	)
	u_clock_loss_detector
	(
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.enable_i(clock_loss_active),
		.mon_clk_i(mon_clk_i),
		.timeout_o(clock_loss_timeout)
	);

	// ----------------------------------------------------------------
	// reset requests, one per cause bit
	// ----------------------------------------------------------------
	assign pin_held = !ext_pin_reset_b_i;
	assign req[`RCR_BIT_RTC] = rtc_reset_enable_flag && rtc_event_i;
	assign req[`RCR_BIT_FLASH] = flash_error_i;
	// comparator reset is active low on its output
	assign req[`RCR_BIT_CMP] = comparator_reset_enable_flag &&
		!comparator_out_i;
	assign req[`RCR_BIT_SW] = wr_hit && sfr_wdata_i[`RCR_BIT_SW];
	assign req[`RCR_BIT_WDT] = watchdog_overflow_i;
	assign req[`RCR_BIT_MCD] = clock_loss_timeout;
	assign req[`RCR_BIT_POR] = supply_reset_enable && supply_low_i;
	assign req[`RCR_BIT_PIN] = pin_held;
	assign any_req = |req;

	// ----------------------------------------------------------------
	// reset sequencer
	// ----------------------------------------------------------------
	// causes arriving during the hold are merged, so a second source is still
	// reported unless the power-on flag is set; the hold stretches while the pin or supply request remains
	always @*
	begin
		next_state = state;
		next_hold_cnt = hold_cnt;
		next_pending = pending;
		case (state)
			ST_RUN:
			begin
				if (any_req)
				begin
					next_state = ST_HOLD;
					next_hold_cnt = HOLD_CYCLES;
					next_pending = req;
				end
			end
			ST_HOLD:
			begin
				next_pending = pending | req;
				if (hold_cnt != {HOLD_W{1'b0}})
					next_hold_cnt = hold_cnt - {{(HOLD_W-1){1'b0}}, 1'b1};
				else if (!pin_held && !req[`RCR_BIT_POR])
					next_state = ST_RUN;
			end
			default:
			begin
				next_state = ST_HOLD;
				next_hold_cnt = HOLD_CYCLES;
			end
		endcase
	end

	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state <= ST_HOLD;
			hold_cnt <= HOLD_CYCLES;
			pending <= `RCR_CAUSE_POR_VAL;
			cause <= `RCR_CAUSE_POR_VAL;
			sys_reset_b_o <= 1'b0;
		end
		else
		begin
			state <= next_state;
			hold_cnt <= next_hold_cnt;
			pending <= next_pending;
			sys_reset_b_o <= (next_state == ST_RUN);
			if (state == ST_HOLD && next_state == ST_RUN)
			begin
				// flags not in pending read zero after release
				cause <= pending;
				if (pending[`RCR_BIT_POR])
					cause <= `RCR_CAUSE_POR_VAL;
			end
		end
	end

	// ----------------------------------------------------------------
	// source enables
	// ----------------------------------------------------------------
	// only the power-on reset loads these (supply enable to one); system resets keep them
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rtc_reset_enable_flag <= `RCR_RTC_EN_RST;
			comparator_reset_enable_flag <= `RCR_CMP_EN_RST;
			clock_loss_reset_enable_flag <= `RCR_MCD_EN_RST;
			supply_reset_enable <= `RCR_SUPPLY_EN_RST;
		end
		else if (wr_hit)
		begin
			rtc_reset_enable_flag <= sfr_wdata_i[`RCR_BIT_RTC];
			comparator_reset_enable_flag <= sfr_wdata_i[`RCR_BIT_CMP];
			clock_loss_reset_enable_flag <= sfr_wdata_i[`RCR_BIT_MCD];
			// an early enable may reset at once; software guards it
			supply_reset_enable <= sfr_wdata_i[`RCR_BIT_POR];
		end
	end

	assign rtc_reset_enable_o = rtc_reset_enable_flag;
	assign comparator_reset_enable_o = comparator_reset_enable_flag;
	assign clock_loss_enable_o = clock_loss_active;
	assign supply_reset_enable_o = supply_reset_enable;

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	assign flag_view = cause;
	// a read-modify-write sees the enables and a zero force bit, so
	// writing the value back neither flips an enable nor resets
	assign rmw_view = {rtc_reset_enable_flag, 1'b0,
		comparator_reset_enable_flag, 1'b0, 1'b0,
		clock_loss_reset_enable_flag, supply_reset_enable,
		1'b0};

	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			sfr_rdata_o <= 8'h00;
		else if (sfr_rd_i && sel)
			sfr_rdata_o <= sfr_rmw_i ? rmw_view : flag_view;
	end

endmodule

// [tb/rcr_reset_cause_recorder_checker.sv]
`timescale 1ns/100ps
module rcr_checker
#(
	parameter HOLD_W = 8,
	parameter [HOLD_W-1:0] HOLD_CYCLES = 2,
	parameter MCD_W = 12,
	parameter [MCD_W-1:0] MCD_CYCLES = 20
)
(
	// clock and reset
	input wire clk_i,
	input wire rst_b_i,
	// register port
	input wire [7:0] sfr_addr_i,
	input wire [7:0] sfr_page_i,
	input wire sfr_wr_i,
	input wire sfr_rd_i,
	input wire sfr_rmw_i,
	input wire [7:0] sfr_wdata_i,
	input wire [7:0] sfr_rdata_o,
	// sources
	input wire ext_pin_reset_b_i,
	input wire supply_low_i,
	input wire mon_clk_i,
	input wire low_power_i,
	input wire watchdog_overflow_i,
	input wire flash_error_i,
	input wire comparator_out_i,
	input wire rtc_event_i,
	// outputs
	input wire sys_reset_b_o,
	input wire rtc_reset_enable_o,
	input wire comparator_reset_enable_o,
	input wire clock_loss_enable_o,
	input wire supply_reset_enable_o
);
	// accesses only count while the system runs
	wire hit = sfr_addr_i == 8'hEF && sfr_page_i == 8'h00 && sys_reset_b_o;
	wire wr_hit = sfr_wr_i && hit;
	reg [7:0] wd_q;
	always @(posedge clk_i)
		wd_q <= sfr_wdata_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_sw_req; wr_hit && sfr_wdata_i[4]; endsequence
	sequence s_held; !sys_reset_b_o [*3]; endsequence
	property p_sw_reset; s_sw_req |=> s_held; endproperty
	a_sw_reset: assert property (p_sw_reset) else $error("no sw reset");
	property p_hold; $fell(sys_reset_b_o) |-> s_held; endproperty
	a_hold: assert property (p_hold) else $error("reset too short");
	property p_pin; !ext_pin_reset_b_i && sys_reset_b_o |=> !sys_reset_b_o;
	endproperty
	a_pin: assert property (p_pin) else $error("pin ignored");
	property p_wdt; watchdog_overflow_i && sys_reset_b_o |=> !sys_reset_b_o;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog ignored");
	property p_wr_en; wr_hit |=> {rtc_reset_enable_o,
		comparator_reset_enable_o, supply_reset_enable_o} ==
		{wd_q[7], wd_q[5], wd_q[1]}; endproperty
	a_wr_en: assert property (p_wr_en) else $error("enable write");
	property p_keep; !wr_hit |=>
		$stable({rtc_reset_enable_o, comparator_reset_enable_o});
	endproperty
	a_keep: assert property (p_keep) else $error("enable lost");
	property p_low_pow; low_power_i |-> !clock_loss_enable_o; endproperty
	a_low_pow: assert property (p_low_pow) else $error("mcd in sleep");
	property p_rmw; sfr_rd_i && hit && sfr_rmw_i && !sfr_wr_i |=>
		(sfr_rdata_o & 8'hFB) == {rtc_reset_enable_o, 1'b0,
		comparator_reset_enable_o, 3'b000, supply_reset_enable_o, 1'b0};
	endproperty
	a_rmw: assert property (p_rmw) else $error("rmw view");
	property p_mcd_en;
		wr_hit |=> low_power_i || clock_loss_enable_o == wd_q[2];
	endproperty
	a_mcd_en: assert property (p_mcd_en) else $error("mcd enable");
	property p_supply;
		supply_low_i && supply_reset_enable_o |=> !sys_reset_b_o;
	endproperty
	a_supply: assert property (p_supply) else $error("supply reset");
endmodule

bind rcr_reset_cause_recorder rcr_checker #(.HOLD_W(HOLD_W),
	.HOLD_CYCLES(HOLD_CYCLES), .MCD_W(MCD_W), .MCD_CYCLES(MCD_CYCLES))
	rcr_checker_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.sfr_addr_i(sfr_addr_i), .sfr_page_i(sfr_page_i), .sfr_wr_i(sfr_wr_i),
	.sfr_rd_i(sfr_rd_i), .sfr_rmw_i(sfr_rmw_i), .sfr_wdata_i(sfr_wdata_i),
	.sfr_rdata_o(sfr_rdata_o), .ext_pin_reset_b_i(ext_pin_reset_b_i),
	.supply_low_i(supply_low_i), .mon_clk_i(mon_clk_i),
	.low_power_i(low_power_i), .watchdog_overflow_i(watchdog_overflow_i),
	.flash_error_i(flash_error_i), .comparator_out_i(comparator_out_i),
	.rtc_event_i(rtc_event_i), .sys_reset_b_o(sys_reset_b_o),
	.rtc_reset_enable_o(rtc_reset_enable_o),
	.comparator_reset_enable_o(comparator_reset_enable_o),
	.clock_loss_enable_o(clock_loss_enable_o),
	.supply_reset_enable_o(supply_reset_enable_o));

// [tb/rcr_reset_cause_recorder_tb.sv]
`timescale 1ns/100ps
module rcr_reset_cause_recorder_tb;
	reg clk_i = 0;
	reg rst_b_i = 0;
	reg [7:0] sfr_addr_i = 8'h00;
	reg [7:0] sfr_page_i = 8'h00;
	reg sfr_wr_i = 0;
	reg sfr_rd_i = 0;
	reg sfr_rmw_i = 0;
	reg [7:0] sfr_wdata_i = 8'h00;
	reg [4:0] src = 5'h00;
	reg run = 1;
	reg mon = 0;
	reg low_power_i = 0;
	reg supply_low = 0;
	wire [7:0] sfr_rdata_o;
	wire sys_reset_b_o;
	integer fails = 0;
	integer tests_run = 0;
	integer i;
	// one byte per source: flash, watchdog, rtc, comparator, pin
	localparam [39:0] EXPS = 40'h01_2080_0840;
	always #25 clk_i = ~clk_i;
	// monitored clock stops only when a scenario clears run
	always @(posedge clk_i)
		if (run)
			mon <= ~mon;
	rcr_reset_cause_recorder #(.HOLD_CYCLES(8'h02), .MCD_CYCLES(12'h014))
		rcr_reset_cause_recorder_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.sfr_addr_i(sfr_addr_i), .sfr_page_i(sfr_page_i),
		.sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rmw_i(sfr_rmw_i),
		.sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
		.ext_pin_reset_b_i(~src[4]), .supply_low_i(supply_low),
		.mon_clk_i(mon),
		.low_power_i(low_power_i), .watchdog_overflow_i(src[1]),
		.flash_error_i(src[0]), .comparator_out_i(~src[3]),
		.rtc_event_i(src[2]), .sys_reset_b_o(sys_reset_b_o),
		.rtc_reset_enable_o(), .comparator_reset_enable_o(),
		.clock_loss_enable_o(), .supply_reset_enable_o());
	task tally_and_finish;
		begin
			if (fails == 0 && tests_run > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task wr(input [7:0] a, input [7:0] p, input [7:0] d);
		begin
			@(posedge clk_i);
			#1 sfr_wr_i = 1;
			sfr_addr_i = a;
			sfr_page_i = p;
			sfr_wdata_i = d;
			@(posedge clk_i);
			#1 sfr_wr_i = 0;
		end
	endtask
	task rd(input m, input [7:0] e);
		begin
			@(posedge clk_i);
			#1 sfr_rd_i = 1;
			sfr_rmw_i = m;
			sfr_addr_i = 8'hEF;
			sfr_page_i = 8'h00;
			@(posedge clk_i);
			#1 sfr_rd_i = 0;
			@(posedge clk_i);
			#1 tests_run = tests_run + 1;
			if (sfr_rdata_o !== e)
			begin
				fails = fails + 1;
				$display("[FAIL] %0t read %h exp %h", $time, sfr_rdata_o, e);
			end
		end
	endtask
	// waits through a system reset, if one is under way or coming
	task waitup;
		integer n;
		begin
			n = 0;
			while (sys_reset_b_o === 1'b1 && n < 300)
			begin
				@(posedge clk_i);
				#1 n = n + 1;
			end
			while (sys_reset_b_o !== 1'b1 && n < 600)
			begin
				@(posedge clk_i);
				#1 n = n + 1;
			end
			if (sys_reset_b_o !== 1'b1)
			begin
				fails = fails + 1;
				$display("[FAIL] %0t reset wait timed out", $time);
				tally_and_finish;
			end
		end
	endtask
	initial
	begin
		repeat (8) @(posedge clk_i);
		#1 rst_b_i = 1;
		waitup;
		rd(0, 8'h02);
		rd(1, 8'h02);
		// supply input is held stable before its enable is written
		wr(8'hEF, 8'h00, 8'hEF);
		rd(1, 8'hA6);
		wr(8'hEE, 8'h00, 8'h00);
		wr(8'hEF, 8'h01, 8'h00);
		rd(1, 8'hA6);
		wr(8'hEF, 8'h00, 8'hB6);
		waitup;
		rd(0, 8'h10);
		rd(1, 8'hA6);
		for (i = 0; i < 5; i = i + 1)
		begin
			@(posedge clk_i);
			#1 src = 5'h01 << i;
			@(posedge clk_i);
			#1 src = 5'h00;
			waitup;
			rd(0, EXPS[i*8 +: 8]);
		end
		@(posedge clk_i);
		#1 supply_low = 1;
		repeat (6) @(posedge clk_i);
		#1 tests_run = tests_run + 1;
		if (sys_reset_b_o !== 1'b0)
		begin
			fails = fails + 1;
			$display("[FAIL] %0t supply reset not held", $time);
		end
		supply_low = 0;
		waitup;
		rd(0, 8'h02);
		low_power_i = 1;
		run = 0;
		repeat (40) @(posedge clk_i);
		#1 tests_run = tests_run + 1;
		if (sys_reset_b_o !== 1'b1)
		begin
			fails = fails + 1;
			$display("[FAIL] %0t clock loss reset in sleep", $time);
		end
		low_power_i = 0;
		repeat (20) @(posedge clk_i);
		#1 tests_run = tests_run + 1;
		if (sys_reset_b_o !== 1'b1)
		begin
			fails = fails + 1;
			$display("[FAIL] %0t clock loss reset too early", $time);
		end
		i = 0;
		while (sys_reset_b_o === 1'b1 && i < 8)
		begin
			@(posedge clk_i);
			#1 i = i + 1;
		end
		// restart the clock inside the hold so the release is clean
		run = 1;
		tests_run = tests_run + 1;
		if (sys_reset_b_o !== 1'b0)
		begin
			fails = fails + 1;
			$display("[FAIL] %0t no clock loss reset", $time);
		end
		waitup;
		rd(0, 8'h04);
		tally_and_finish;
	end
endmodule
